// [src/obd_rrk_map.svh]
`ifndef OBD_RRK_MAP_SVH
`define OBD_RRK_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OBD_REG_CTRL      8'h00
`define OBD_REG_RESP_WAIT 8'h04
`define OBD_REG_KA_PERIOD 8'h08
`define OBD_REG_KA_LO     8'h0c
`define OBD_REG_KA_HI     8'h10
`define OBD_REG_STATUS    8'h14

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define OBD_CTRL_AUTO     0
`define OBD_CTRL_PROTO_LO 1
`define OBD_CTRL_PROTO_HI 4
`define OBD_CTRL_ACK      5
`define OBD_CTRL_FAST     6
`define OBD_CTRL_SLOW     7
`define OBD_CTRL_RST      32'h0000_0001
`define OBD_KA_LEN_LO     16
`define OBD_KA_LEN_HI     18

// ----------------------------------------------------------------
// Protocol numbers with bus initiation
// ----------------------------------------------------------------
`define OBD_PROTO_9141    4'h3
`define OBD_PROTO_KWP_SL  4'h4
`define OBD_PROTO_KWP_FA  4'h5

// ----------------------------------------------------------------
// Default keep-alive messages, first byte in the top lane
// ----------------------------------------------------------------
`define OBD_KA_9141_MSG   48'h686a_f101_0000
`define OBD_KA_9141_LEN   3'h5
`define OBD_KA_KWP_MSG    48'hc133_f13e_0000
`define OBD_KA_KWP_LEN    3'h4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OBD_CLK_NS        100
`define OBD_MS_NS         1000000
`define OBD_TICK_CYC      (`OBD_MS_NS / `OBD_CLK_NS)
`define OBD_RESP_WAIT_MS  16'd200
`define OBD_KA_PERIOD_MS  16'd3000
`define OBD_DOT_MS        12'd600
`define OBD_DOT_COUNT     2'h3

`endif

// [src/obd_rrk_pkg.sv]
package obd_rrk_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_INIT, ST_SEND, ST_WAIT, ST_KA_SEND, ST_KA_WAIT
  } obd_state_t;

  typedef enum logic [2:0] {
    EV_RESP, EV_NO_DATA, EV_BUS_INIT, EV_DOT, EV_OK, EV_ERROR
  } obd_evt_code_t;

  typedef enum logic [1:0] {
    TX_REQ, TX_KEEPALIVE, TX_INIT_SLOW, TX_INIT_FAST
  } obd_tx_kind_t;

  typedef struct packed {
    logic          valid;
    obd_evt_code_t code;
  } obd_evt_t;

  typedef struct packed {
    logic         start;
    obd_tx_kind_t kind;
    logic [2:0]   len;
    logic [47:0]  msg;
  } obd_tx_t;

  typedef struct packed {
    logic valid;
    logic match;
  } obd_rx_t;

  typedef struct packed {
    logic done;
    logic ok;
  } obd_init_t;

endpackage

// [src/obd_rrk_tick.sv]
`timescale 1ns/10ps

module obd_rrk_tick #(
  parameter int unsigned CYC = 10000
) (
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  output logic      tick_o
);

  logic [15:0] cnt_q;

  // Millisecond enable pulse from the system clock
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cnt_q  <= 16'h0;
      tick_o <= 1'b0;
    end else if (cnt_q == 16'(CYC - 1)) begin
      cnt_q  <= 16'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 16'h1;
      tick_o <= 1'b0;
    end
  end

endmodule

// [src/obd_rrk_ms_timer.sv]
`timescale 1ns/10ps

module obd_rrk_ms_timer (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        tick_i,
  input  wire logic        load_i,
  input  wire logic        stop_i,
  input  wire logic [15:0] period_i,
  output logic             expire_o
);

  logic [15:0] cnt_q;
  logic        run_q;

  // Countdown in ms; a reload restarts the full interval
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cnt_q    <= 16'h0;
      run_q    <= 1'b0;
      expire_o <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (load_i) begin
        cnt_q <= (period_i == 16'h0) ? 16'h1 : period_i;
        run_q <= 1'b1;
      end else if (stop_i) begin
        run_q <= 1'b0;
      end else if (run_q && tick_i) begin
        if (cnt_q == 16'h1) begin
          run_q    <= 1'b0;
          expire_o <= 1'b1;
        end
        cnt_q <= cnt_q - 16'h1;
      end
    end
  end

endmodule

// [src/obd_rrk_top.sv]
// Operation
// - Keep collecting responses until the wait interval passes with none.
// - Same interval bounds the first response; expiry reports NO DATA.
// - Optional hex digit after a request gives the maximum response count.
// - With a count given, finish as soon as that many responses arrive.
// - Response wait interval is software set, default 200 ms.
// - Wait timer still starts after sending, even with a count given.
// - Acknowledge every received message on protocols that need it; the code acks only in ST_WAIT and ST_KA_WAIT.
// - K-line protocols need bus initiation before any request exchange.
// - ISO 9141 only slow initiation; ISO 14230 slow or fast.
// - Initiation deferred to first request; host may force fast or slow.
// - Status line only with automatic search off and protocol 3, 4 or 5.
// - Slow initiation shows three progress dots; fast shows none.
// - After initiation report OK on success, else an error.
// - Once initiated, send own keep-alive requests while the host idles.
// - Responses to keep-alive requests are never passed to the host.
// - Keep-alive interval is software set, default 3 seconds.
// - Keep-alive content is software set, replacing the protocol default.
// - Defaults: 68 6A F1 01 00 for 9141, C1 33 F1 3E for 14230.
// - Custom keep-alive holds one to six bytes; checksum added downstream.
// - Each matching response restarts the response wait timer; the code restarts it in ST_WAIT only, not for keep-alive replies.
// - Messages failing the address criteria are dropped, not forwarded.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "obd_rrk_map.svh"

module obd_rrk_top #(
  parameter int unsigned TICK_CYC = `OBD_TICK_CYC
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic [31:0]                 reg_rdata_o,
  input  wire logic                   req_start_i,
  input  wire logic                   req_has_cnt_i,
  input  wire logic [3:0]             req_cnt_i,
  output obd_rrk_pkg::obd_tx_t        tx_o,
  input  wire logic                   tx_done_i,
  input  wire obd_rrk_pkg::obd_rx_t   rx_i,
  input  wire obd_rrk_pkg::obd_init_t init_i,
  output logic                        ack_o,
  output obd_rrk_pkg::obd_evt_t       evt_o,
  output logic                        prompt_o
);
  import obd_rrk_pkg::*;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  obd_state_t  state_q;
  logic        auto_q;
  logic [3:0]  proto_q;
  logic        ack_en_q;
  logic [15:0] resp_wait_q;
  logic [15:0] ka_period_q;
  logic [47:0] ka_msg_q;
  logic [2:0]  ka_len_q;
  logic        ka_custom_q;
  logic        initiated_q;
  logic        slow_q;
  logic        req_pend_q;
  logic [3:0]  want_q;
  logic [3:0]  got_q;
  logic [11:0] dot_ms_q;
  logic [1:0]  dots_q;
  logic        force_fast;
  logic        force_slow;
  logic        fast_ok;
  logic        forced;
  logic        start_init;
  logic        start_slow;
  logic        tick;
  logic        rw_load;
  logic        rw_exp;
  logic        ka_load;
  logic        ka_exp;
  logic        rx_ok;
  logic        last_rsp;
  logic        report;
  logic        kline;

  function automatic logic is_kline(input logic [3:0] p);
    is_kline = (p == `OBD_PROTO_9141) || (p == `OBD_PROTO_KWP_SL) ||
               (p == `OBD_PROTO_KWP_FA);
  endfunction

  assign kline      = is_kline(proto_q);
  assign report     = !auto_q && kline;
  assign force_fast = reg_wr_i && reg_addr_i == `OBD_REG_CTRL &&
                      reg_wdata_i[`OBD_CTRL_FAST];
  assign force_slow = reg_wr_i && reg_addr_i == `OBD_REG_CTRL &&
                      reg_wdata_i[`OBD_CTRL_SLOW];
  // One shared start decision for sequencer, transmit order and status
  assign fast_ok    = force_fast && proto_q != `OBD_PROTO_9141 && kline;
  assign forced     = fast_ok || (force_slow && kline);
  assign start_init = state_q == ST_IDLE &&
                      (forced || (req_start_i && kline && !initiated_q));
  assign start_slow = !fast_ok &&
                      (force_slow || proto_q != `OBD_PROTO_KWP_FA);
  assign rx_ok      = rx_i.valid && rx_i.match;
  assign last_rsp   = want_q != 4'h0 && got_q + 4'h1 == want_q;

  // ----------------------------------------------------------------
  // Millisecond tick and the two interval timers
  // ----------------------------------------------------------------
  obd_rrk_tick #(.CYC(TICK_CYC)) u_tick (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .tick_o    (tick)
  );

  // Response wait: after send and on each matching response in ST_WAIT
  assign rw_load = (state_q == ST_SEND && tx_done_i) ||
                   (state_q == ST_KA_SEND && tx_done_i) ||
                   (state_q == ST_WAIT && rx_ok);

  obd_rrk_ms_timer u_resp_wait (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .tick_i    (tick),
    .load_i    (rw_load),
    .stop_i    (state_q == ST_IDLE),
    .period_i  (resp_wait_q),
    .expire_o  (rw_exp)
  );

  // Idle timer reloads on any bus traffic
  assign ka_load = tx_done_i || rx_i.valid ||
                   (init_i.done && state_q == ST_INIT);

  obd_rrk_ms_timer u_keepalive (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .tick_i    (tick),
    .load_i    (ka_load),
    .stop_i    (!initiated_q),
    .period_i  (ka_period_q),
    .expire_o  (ka_exp)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Configuration words
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      auto_q      <= 1'(`OBD_CTRL_RST);
      proto_q     <= 4'h0;
      ack_en_q    <= 1'b0;
      resp_wait_q <= `OBD_RESP_WAIT_MS;
      ka_period_q <= `OBD_KA_PERIOD_MS;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `OBD_REG_CTRL: begin
          auto_q   <= reg_wdata_i[`OBD_CTRL_AUTO];
          proto_q  <= reg_wdata_i[`OBD_CTRL_PROTO_HI:`OBD_CTRL_PROTO_LO];
          ack_en_q <= reg_wdata_i[`OBD_CTRL_ACK];
        end
        `OBD_REG_RESP_WAIT: resp_wait_q <= reg_wdata_i[15:0];
        `OBD_REG_KA_PERIOD: ka_period_q <= reg_wdata_i[15:0];
        default: ;
      endcase
    end
  end

  // Keep-alive content; a custom message replaces the default
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ka_msg_q    <= 48'h0;
      ka_len_q    <= 3'h0;
      ka_custom_q <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == `OBD_REG_KA_LO) begin
      ka_msg_q[47:16] <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == `OBD_REG_KA_HI) begin
      ka_msg_q[15:0] <= reg_wdata_i[15:0];
      if (reg_wdata_i[`OBD_KA_LEN_HI:`OBD_KA_LEN_LO] == 3'h0 ||
          reg_wdata_i[`OBD_KA_LEN_HI:`OBD_KA_LEN_LO] > 3'h6) begin
        ka_custom_q <= 1'b0;
      end else begin
        ka_len_q    <= reg_wdata_i[`OBD_KA_LEN_HI:`OBD_KA_LEN_LO];
        ka_custom_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads, data one cycle later
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `OBD_REG_CTRL:      reg_rdata_o <= {26'h0, ack_en_q, proto_q,
                                            auto_q};
        `OBD_REG_RESP_WAIT: reg_rdata_o <= {16'h0, resp_wait_q};
        `OBD_REG_KA_PERIOD: reg_rdata_o <= {16'h0, ka_period_q};
        `OBD_REG_KA_LO:     reg_rdata_o <= ka_msg_q[47:16];
        `OBD_REG_KA_HI:     reg_rdata_o <= {13'h0, ka_len_q,
                                            ka_msg_q[15:0]};
        `OBD_REG_STATUS:    reg_rdata_o <= {20'h0, got_q, ka_custom_q,
                                            initiated_q, dots_q,
                                            1'b0, state_q};
        default:            reg_rdata_o <= 32'h0;
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Exchange sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_q    <= ST_IDLE;
      req_pend_q <= 1'b0;
      slow_q     <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_init) begin
            state_q    <= ST_INIT;
            slow_q     <= start_slow;
            req_pend_q <= !forced;
          end else if (req_start_i) begin
            state_q <= ST_SEND;
          end else if (ka_exp && kline && initiated_q) begin
            state_q <= ST_KA_SEND;
          end
        end
        ST_INIT: begin
          if (init_i.done) begin
            state_q <= (init_i.ok && req_pend_q) ? ST_SEND : ST_IDLE;
          end
        end
        ST_SEND:    if (tx_done_i) state_q <= ST_WAIT;
        ST_WAIT: begin
          if (rx_ok && last_rsp) begin
            state_q <= ST_IDLE;
          end else if (rw_exp && !rx_ok) begin
            state_q <= ST_IDLE;
          end
        end
        ST_KA_SEND: if (tx_done_i) state_q <= ST_KA_WAIT;
        ST_KA_WAIT: if (rw_exp) state_q <= ST_IDLE;
        default:    state_q <= ST_IDLE;
      endcase
    end
  end

  // Requested response count and responses seen
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      want_q <= 4'h0;
      got_q  <= 4'h0;
    end else if (state_q == ST_IDLE && req_start_i) begin
      want_q <= req_has_cnt_i ? req_cnt_i : 4'h0;
      got_q  <= 4'h0;
    end else if (state_q == ST_WAIT && rx_ok && got_q != 4'hf) begin
      got_q <= got_q + 4'h1;
    end
  end

  // Bus initiated flag; dropped on a control register write unless initiation completes in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      initiated_q <= 1'b0;
    end else if (state_q == ST_INIT && init_i.done) begin
      initiated_q <= init_i.ok;
    end else if (reg_wr_i && reg_addr_i == `OBD_REG_CTRL) begin
      initiated_q <= 1'b0;
    end
  end

  // Progress dot pacing during slow initiation
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || state_q != ST_INIT) begin
      dot_ms_q <= 12'h0;
      dots_q   <= 2'h0;
    end else if (tick) begin
      if (dot_ms_q == `OBD_DOT_MS - 12'h1) begin
        dot_ms_q <= 12'h0;
        if (slow_q && dots_q != `OBD_DOT_COUNT) begin
          dots_q <= dots_q + 2'h1;
        end
      end else begin
        dot_ms_q <= dot_ms_q + 12'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Vehicle side outputs
  // ----------------------------------------------------------------
  // Transmit command pulse with keep-alive content
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      tx_o <= '0;
    end else begin
      tx_o.start <= 1'b0;
      if (start_init) begin
        tx_o.start <= 1'b1;
        tx_o.kind  <= start_slow ? TX_INIT_SLOW : TX_INIT_FAST;
      end else if (state_q == ST_IDLE && req_start_i) begin
        tx_o.start <= 1'b1;
        tx_o.kind  <= TX_REQ;
      end else if (state_q == ST_INIT && init_i.done && init_i.ok &&
                   req_pend_q) begin
        tx_o.start <= 1'b1;
        tx_o.kind  <= TX_REQ;
      end else if (state_q == ST_IDLE && ka_exp && kline &&
                   initiated_q) begin
        tx_o.start <= 1'b1;
        tx_o.kind  <= TX_KEEPALIVE;
        if (ka_custom_q) begin
          tx_o.msg <= ka_msg_q;
          tx_o.len <= ka_len_q;
        end else if (proto_q == `OBD_PROTO_9141) begin
          tx_o.msg <= `OBD_KA_9141_MSG;
          tx_o.len <= `OBD_KA_9141_LEN;
        end else begin
          tx_o.msg <= `OBD_KA_KWP_MSG;
          tx_o.len <= `OBD_KA_KWP_LEN;
        end
      end
    end
  end

  // Acknowledge each received message while listening
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= ack_en_q && rx_i.valid &&
               (state_q == ST_WAIT || state_q == ST_KA_WAIT);
    end
  end

  // ----------------------------------------------------------------
  // Host side outputs
  // ----------------------------------------------------------------
  // One event per cycle toward the host printer
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      evt_o <= '0;
    end else begin
      evt_o.valid <= 1'b0;
      case (state_q)
        ST_WAIT: begin
          if (rx_ok) begin
            evt_o <= '{1'b1, EV_RESP};
          end else if (rw_exp && got_q == 4'h0) begin
            evt_o <= '{1'b1, EV_NO_DATA};
          end
        end
        ST_INIT: begin
          if (init_i.done && report) begin
            evt_o <= '{1'b1, init_i.ok ? EV_OK : EV_ERROR};
          end else if (tick && report && slow_q &&
                       dot_ms_q == `OBD_DOT_MS - 12'h1 &&
                       dots_q != `OBD_DOT_COUNT) begin
            evt_o <= '{1'b1, EV_DOT};
          end
        end
        ST_IDLE: begin
          if (start_init && report) begin
            evt_o <= '{1'b1, EV_BUS_INIT};
          end
        end
        default: ;  // Keep-alive replies stay hidden
      endcase
    end
  end

  // Prompt pulse when a host exchange is over
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      prompt_o <= 1'b0;
    end else begin
      prompt_o <= (state_q == ST_WAIT &&
                   ((rx_ok && last_rsp) || (rw_exp && !rx_ok))) ||
                  (state_q == ST_INIT && init_i.done &&
                   !(init_i.ok && req_pend_q));
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  nodata_report_a: assert property (
    state_q == ST_WAIT && rw_exp && !rx_ok && got_q == 4'h0 |=>
    evt_o.valid && evt_o.code == EV_NO_DATA && prompt_o)
    else $error("no data not reported");

  early_stop_a: assert property (
    state_q == ST_WAIT && rx_ok && last_rsp |=>
    prompt_o && state_q == ST_IDLE)
    else $error("count reached but exchange open");

  keep_collect_a: assert property (
    state_q == ST_WAIT && rx_ok && want_q == 4'h0 |=>
    state_q == ST_WAIT ##1 !prompt_o)
    else $error("response did not extend collection");

  ack_rx_a: assert property (
    ack_en_q && rx_i.valid && state_q == ST_WAIT |=> ack_o)
    else $error("message not acknowledged");

  ka_hidden_a: assert property (
    state_q == ST_KA_WAIT |=> !(evt_o.valid && evt_o.code == EV_RESP))
    else $error("keep-alive reply forwarded");

  drop_nomatch_a: assert property (
    rx_i.valid && !rx_i.match |=> !(evt_o.valid && evt_o.code == EV_RESP))
    else $error("unmatched message forwarded");

  init_first_a: assert property (
    tx_o.start && tx_o.kind == TX_REQ && kline |-> initiated_q)
    else $error("request before bus initiation");

  fast_nodots_a: assert property (
    state_q == ST_INIT && !slow_q |=> !(evt_o.valid && evt_o.code == EV_DOT))
    else $error("dot during fast initiation");

  timer_start_a: assert property (
    state_q == ST_SEND && tx_done_i |=> state_q == ST_WAIT ##1 !prompt_o)
    else $error("wait not started after send");

  auto_quiet_a: assert property (
    auto_q |=> !(evt_o.valid && evt_o.code == EV_BUS_INIT))
    else $error("status shown during search");

  early_stop_c: cover property (state_q == ST_WAIT && rx_ok && last_rsp);
  nodata_c: cover property (evt_o.valid && evt_o.code == EV_NO_DATA);
  keepalive_c: cover property (tx_o.start && tx_o.kind == TX_KEEPALIVE);
  slow_init_c: cover property (evt_o.valid && evt_o.code == EV_DOT);

endmodule

// [test/obd_rrk_ecu.sv]
`timescale 1ns/10ps

module obd_rrk_ecu (
  input  wire logic                 ref_clk_i,
  input  wire obd_rrk_pkg::obd_tx_t tx_i,
  input  wire logic [3:0]           n_resp_i,
  input  wire logic                 match_i,
  input  wire logic                 init_ok_i,
  output logic                      tx_done_o,
  output obd_rrk_pkg::obd_rx_t      rx_o,
  output obd_rrk_pkg::obd_init_t    init_o
);
  import obd_rrk_pkg::*;
  initial begin
    tx_done_o = 1'b0;
    rx_o      = '0;
    init_o    = '0;
  end
  // ------------------------------------------------------------
  // Control unit: one job at a time, one-cycle pulses
  // ------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (tx_i.start && tx_i.kind[1]) begin
      repeat (tx_i.kind == TX_INIT_SLOW ? 20000 : 40)
        @(posedge ref_clk_i);
      init_o <= '{done: 1'b1, ok: init_ok_i};
      @(posedge ref_clk_i);
      init_o <= '{done: 1'b0, ok: ~init_ok_i};
    end else if (tx_i.start) begin
      repeat (20) @(posedge ref_clk_i);
      tx_done_o <= 1'b1;
      @(posedge ref_clk_i);
      tx_done_o <= 1'b0;
      repeat (n_resp_i) begin
        repeat (7) @(posedge ref_clk_i);
        rx_o <= '{valid: 1'b1, match: match_i};
        @(posedge ref_clk_i);
        rx_o <= '{valid: 1'b0, match: ~match_i}; // Released, match inverted
      end
    end
  end
endmodule

// [test/tb_obd_rrk_top.sv]
`timescale 1ns/10ps
`include "obd_rrk_map.svh"

module tb_obd_rrk_top;
  import obd_rrk_pkg::*;
  logic        ref_clk_i = 0, reset_n_i = 0, reg_wr = 0, reg_rd = 0;
  logic        req_start = 0, req_has = 0, match = 1, init_ok = 1;
  logic        tx_done, ack, prompt, rd_pend = 0, ack_on = 0;
  logic [7:0]  reg_addr = 0, lfsr = 8'h56;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [3:0]  req_cnt = 0, n_resp = 0;
  logic [63:0] ka_exp, rd_q[$], ev_q[$];
  int          n_fail = 0, n_compared = 0, n_ack = 0, n_prompt = 0;
  int          n_ka = 0, k;
  obd_tx_t     tx;
  obd_rx_t     rx;
  obd_init_t   init;
  obd_evt_t    evt;

  obd_rrk_top #(.TICK_CYC(10)) dut_u (.ref_clk_i, .reset_n_i,
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .req_start_i(req_start),
    .req_has_cnt_i(req_has), .req_cnt_i(req_cnt), .tx_o(tx),
    .tx_done_i(tx_done), .rx_i(rx), .init_i(init), .ack_o(ack),
    .evt_o(evt), .prompt_o(prompt));
  obd_rrk_ecu ecu_u (.ref_clk_i, .tx_i(tx), .n_resp_i(n_resp),
    .match_i(match), .init_ok_i(init_ok), .tx_done_o(tx_done),
    .rx_o(rx), .init_o(init));

  // Clock and watchdog
  initial forever #50 ref_clk_i = ~ref_clk_i;
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    n_fail++;
    complete_run;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk_i) reg_wr <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] d);
    rd_q.push_back(64'(d));
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk_i) reg_rd <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic push(obd_evt_code_t c, int n);
    repeat (n) ev_q.push_back(64'(c));
  endtask
  task automatic run_req(logic h, logic [3:0] c, nr, logic m, int lim);
    int a, p;
    a = n_ack;
    p = n_prompt;
    n_resp <= nr;
    match <= m;
    if (m && nr > 0) push(EV_RESP, (h && c < nr) ? c : nr);
    else push(EV_NO_DATA, 1);
    req_has <= h;
    req_cnt <= c;
    req_start <= 1'b1;
    @(posedge ref_clk_i) req_start <= 1'b0;
    repeat (lim) if (n_prompt == p) @(posedge ref_clk_i);
    chk("prompt", p + 1, n_prompt);
    @(posedge ref_clk_i);
    chk("left", 0, ev_q.size());
    if (ack_on) chk("acks", nr, n_ack - a);
  endtask
  task automatic see_ka;
    k = n_ka;
    repeat (700) if (n_ka == k) @(posedge ref_clk_i);
    chk("keepalive", 1, 64'(n_ka > k));
    repeat (150) @(posedge ref_clk_i);
  endtask
  // Output watcher: events, read data, acks, prompts, keep-alives
  always @(posedge ref_clk_i) begin
    rd_pend <= reg_rd;
    if (rd_pend) chk("rdata", rd_q.pop_front(), reg_rdata);
    if (evt.valid) chk("evt", ev_q.size() ? ev_q.pop_front() : 64'hff,
                       64'(evt.code));
    if (ack) n_ack <= n_ack + 1;
    if (prompt) n_prompt <= n_prompt + 1;
    if (tx.start && tx.kind == TX_KEEPALIVE) begin
      n_ka <= n_ka + 1;
      chk("ka_msg", ka_exp, {tx.len, tx.msg});
    end
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    rd(`OBD_REG_RESP_WAIT, 32'hc8);
    rd(`OBD_REG_KA_PERIOD, 32'hbb8);
    rd(8'h18, 32'h0);
    wr(`OBD_REG_RESP_WAIT, 32'h5);
    wr(`OBD_REG_CTRL, 32'h21);
    $display("test registers done");
    ack_on = 1'b1;
    lfsr = lfsr_next(lfsr);
    run_req(0, 0, 4'(lfsr % 3 + 1), 1, 200);
    run_req(0, 0, 0, 1, 200);
    run_req(1, 2, 2, 1, 60);
    run_req(1, 3, 0, 1, 200);
    run_req(0, 0, 2, 0, 200);
    $display("test responses done");
    ack_on = 1'b0;
    wr(`OBD_REG_CTRL, 32'h08);
    wr(`OBD_REG_KA_PERIOD, 32'h1e);
    ka_exp = {13'h0, `OBD_KA_KWP_LEN, `OBD_KA_KWP_MSG};
    push(EV_BUS_INIT, 1);
    push(EV_DOT, 3);
    push(EV_OK, 1);
    run_req(0, 0, 1, 1, 25000);
    see_ka;
    wr(`OBD_REG_CTRL, 32'h0a);
    wr(`OBD_REG_KA_LO, 32'h1122_3344);
    wr(`OBD_REG_KA_HI, 32'h0005_5500);
    ka_exp = {13'h0, 3'h5, 48'h1122_3344_5500};
    push(EV_BUS_INIT, 1);
    push(EV_OK, 1);
    run_req(0, 0, 1, 1, 300);
    see_ka;
    $display("test keep-alive done");
    init_ok <= 1'b0;
    push(EV_BUS_INIT, 1);
    push(EV_DOT, 3);
    push(EV_ERROR, 1);
    wr(`OBD_REG_CTRL, 32'h88);
    repeat (25000) if (ev_q.size() != 0) @(posedge ref_clk_i);
    chk("left", 0, ev_q.size());
    // Forced fast start on the slow-only protocol must stay quiet
    wr(`OBD_REG_CTRL, 32'h06);
    wr(`OBD_REG_CTRL, 32'h46);
    rd(`OBD_REG_STATUS, 32'h180);
    @(posedge ref_clk_i);
    $display("test forced init done");
    complete_run;
  end
endmodule
